/* File: psch_consts.svh */
`ifndef PSCH_CONSTS_SVH
`define PSCH_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSCH_ADDR_CMD 12'h000
`define PSCH_ADDR_STATUS 12'h004
`define PSCH_ADDR_CTRLWORD 12'h008
// ----------------------------------------
// Command codes, signed 16 bit
// ----------------------------------------
`define PSCH_CMD_RESET 16'hfffa
`define PSCH_CMD_FACT_SAVE_MID 16'hfffb
`define PSCH_CMD_USER_MID 16'hfffc
`define PSCH_CMD_FACT_CLR_ID 16'hfffd
`define PSCH_CMD_USER_LOAD 16'hfffe
`define PSCH_CMD_FACT_LOAD 16'hffff
`define PSCH_CMD_SAVE 16'h0001
// ----------------------------------------
// Status fields and reset values
// ----------------------------------------
`define PSCH_CMD_RST 16'h0000
`define PSCH_CW_RST 16'h0000
`define PSCH_ST_BUSY 0
`define PSCH_ST_CENTRING 1
`define PSCH_ST_ABORTED 2
`define PSCH_ST_BLOCKED 3
`endif

/* File: psch_pkg.sv */
package psch_pkg;
  typedef enum logic [2:0] {
    PSCH_IDLE = 3'b000,
    PSCH_WAIT_PARAM = 3'b001,
    PSCH_WAIT_SAVE = 3'b010,
    PSCH_CENTRE = 3'b011,
    PSCH_RESET = 3'b100
  } psch_state_t;
endpackage

/* File: psch_sync.sv */
module psch_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic stage1_ff;
  logic stage2_ff;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end
  assign dout = stage2_ff;
endmodule // psch_sync

/* File: psch_cmd_handler.sv */
// What this block does
// RL1: Minus six requests a full drive reset.
// RL2: Minus five: factory load, save, then centre.
// RL3: Minus four: user load, then centre.
// RL4: Minus three: factory load, clear identity, save.
// RL5: Minus two: user load, no save.
// RL6: Minus one: factory load, no save.
// RL7: Plus one saves parameters to memory.
// RL8: Controller writes only defined codes, signed 16-bit.
// RL9: Command register is volatile, readable and writable.
// RL10: Constant control word ignored while centring.
// RL11: Control word change aborts centring.
// RL12: Old run commands never resume after centring.
// RL13: Unsupported codes cause no action.
`include "psch_consts.svh"
module psch_cmd_handler (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Cyclic control word from the fieldbus
  input wire logic [15:0] ctrlWord,
  input wire logic ctrlWordValid,
  // Parameter store handshake
  output logic loadFactory_ff,
  output logic loadUser_ff,
  output logic saveNvm_ff,
  output logic clearIdent_ff,
  input wire logic storeDone,
  // Drive actions
  output logic driveReset_ff,
  output logic centreStart_ff,
  output logic centreAbort_ff,
  input wire logic centreDone,
  output logic [15:0] ctrlWordOut_ff,
  output logic ctrlWordOutValid_ff
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstnSync;
  psch_sync u_rst_sync (
    .clk(ref_clk),
    .rstN(rstn),
    .din(1'b1),
    .dout(rstnSync)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic wrCmd;
  logic centreEntry;
  logic [15:0] cmd_ff;
  logic [15:0] cmdPend_ff;
  logic cmdNew_ff;
  psch_pkg::psch_state_t state_ff;
  psch_pkg::psch_state_t nxt_state;
  logic aborted_ff;
  logic blocked_ff;
  logic [15:0] cwHeld_ff;
  logic knownCmd;
  logic centreMove;
  logic cwChanged;
  logic busy;
  logic [1:0] step_ff;

  assign wrCmd = psel && penable && pwrite && (paddr == `PSCH_ADDR_CMD);
  assign busy = (state_ff != psch_pkg::PSCH_IDLE);

  // Zero wait states: pready is asserted in every access phase.
  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr != `PSCH_ADDR_CMD)
        && (paddr != `PSCH_ADDR_STATUS) && (paddr != `PSCH_ADDR_CTRLWORD);
    end
  end

  // The command register lives only in flops, so it is lost at reset.
  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      cmd_ff <= `PSCH_CMD_RST; // see RL9
    end else if (wrCmd && pready) begin
      cmd_ff <= pwdata[15:0]; // see RL9
    end
  end

  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PSCH_ADDR_CMD: prdata <= {{16{cmd_ff[15]}}, cmd_ff}; // see RL9
        `PSCH_ADDR_STATUS: prdata <= {28'h000_0000, blocked_ff, aborted_ff,
                                      centreMove, busy};
        `PSCH_ADDR_CTRLWORD: prdata <= {16'h0000, cwHeld_ff};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // A write while busy is latched and run once the handler is idle.
  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      cmdNew_ff <= 1'b0;
      cmdPend_ff <= `PSCH_CMD_RST;
    end else if (wrCmd && pready) begin
      cmdNew_ff <= 1'b1;
      cmdPend_ff <= pwdata[15:0];
    end else if (!busy) begin
      cmdNew_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb begin
    case (cmdPend_ff)
      `PSCH_CMD_RESET, `PSCH_CMD_FACT_SAVE_MID, `PSCH_CMD_USER_MID,
      `PSCH_CMD_FACT_CLR_ID, `PSCH_CMD_USER_LOAD, `PSCH_CMD_FACT_LOAD,
      `PSCH_CMD_SAVE: knownCmd = 1'b1;
      default: knownCmd = 1'b0; // see RL13
    endcase
  end

  assign centreMove = (state_ff == psch_pkg::PSCH_CENTRE);
  assign cwChanged = ctrlWordValid && (ctrlWord != cwHeld_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      psch_pkg::PSCH_IDLE: begin
        if (cmdNew_ff && knownCmd) begin
          if (cmdPend_ff == `PSCH_CMD_RESET) begin
            nxt_state = psch_pkg::PSCH_RESET; // see RL1
          end else if (cmdPend_ff == `PSCH_CMD_SAVE) begin
            nxt_state = psch_pkg::PSCH_WAIT_SAVE; // see RL7
          end else begin
            nxt_state = psch_pkg::PSCH_WAIT_PARAM;
          end
        end
      end
      psch_pkg::PSCH_WAIT_PARAM: begin
        if (storeDone) begin
          if (step_ff == 2'd1 || step_ff == 2'd3) begin
            nxt_state = psch_pkg::PSCH_WAIT_SAVE; // see RL2, RL4
          end else if (step_ff == 2'd2) begin
            nxt_state = psch_pkg::PSCH_CENTRE; // see RL3
          end else begin
            nxt_state = psch_pkg::PSCH_IDLE; // see RL5
          end
        end
      end
      psch_pkg::PSCH_WAIT_SAVE: begin
        if (storeDone) begin
          nxt_state = (step_ff == 2'd1) ? psch_pkg::PSCH_CENTRE
                                        : psch_pkg::PSCH_IDLE; // see RL2
        end
      end
      psch_pkg::PSCH_CENTRE: begin
        if (cwChanged || centreDone) begin
          nxt_state = psch_pkg::PSCH_IDLE; // see RL11
        end
      end
      psch_pkg::PSCH_RESET: nxt_state = psch_pkg::PSCH_IDLE;
      default: nxt_state = psch_pkg::PSCH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      state_ff <= psch_pkg::PSCH_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Step: 1 = save then centre, 2 = centre only, 0 = no follow-up.
  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      step_ff <= 2'd0;
    end else if (state_ff == psch_pkg::PSCH_IDLE && cmdNew_ff) begin
      if (cmdPend_ff == `PSCH_CMD_FACT_SAVE_MID) begin
        step_ff <= 2'd1; // see RL2
      end else if (cmdPend_ff == `PSCH_CMD_USER_MID) begin
        step_ff <= 2'd2; // see RL3
      end else if (cmdPend_ff == `PSCH_CMD_FACT_CLR_ID) begin
        step_ff <= 2'd3; // see RL4
      end else begin
        step_ff <= 2'd0;
      end
    end
  end

  // ----------------------------------------
  // Action strobes
  // ----------------------------------------
  logic startCmd;
  assign startCmd = (state_ff == psch_pkg::PSCH_IDLE) && cmdNew_ff && knownCmd;
  assign centreEntry = (state_ff != psch_pkg::PSCH_CENTRE)
    && (nxt_state == psch_pkg::PSCH_CENTRE);

  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      loadFactory_ff <= 1'b0;
      loadUser_ff <= 1'b0;
      clearIdent_ff <= 1'b0;
      driveReset_ff <= 1'b0;
    end else begin
      loadFactory_ff <= startCmd && (cmdPend_ff == `PSCH_CMD_FACT_SAVE_MID
        || cmdPend_ff == `PSCH_CMD_FACT_CLR_ID
        || cmdPend_ff == `PSCH_CMD_FACT_LOAD); // see RL6
      loadUser_ff <= startCmd && (cmdPend_ff == `PSCH_CMD_USER_MID
        || cmdPend_ff == `PSCH_CMD_USER_LOAD); // see RL5
      clearIdent_ff <= startCmd && (cmdPend_ff == `PSCH_CMD_FACT_CLR_ID); // see RL4
      driveReset_ff <= startCmd && (cmdPend_ff == `PSCH_CMD_RESET); // see RL1
    end
  end

  // Save follows the load for minus five and minus three, or runs alone for plus one.
  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      saveNvm_ff <= 1'b0;
    end else begin
      saveNvm_ff <= (startCmd && cmdPend_ff == `PSCH_CMD_SAVE) // see RL7
        || (state_ff == psch_pkg::PSCH_WAIT_PARAM && storeDone
            && (step_ff == 2'd1 || step_ff == 2'd3)); // see RL4
    end
  end

  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      centreStart_ff <= 1'b0;
      centreAbort_ff <= 1'b0;
    end else begin
      centreStart_ff <= centreEntry;
      centreAbort_ff <= centreMove && cwChanged && !centreDone; // see RL11
    end
  end

  // Step 3 shares the save path but never centres.
  // ----------------------------------------
  // Control word gating
  // ----------------------------------------
  // Blocking stays set after centring until the control word changes,
  // so a run word that persisted from before cannot restart the old run.
  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      cwHeld_ff <= `PSCH_CW_RST;
    end else if (ctrlWordValid) begin
      cwHeld_ff <= ctrlWord;
    end
  end

  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      blocked_ff <= 1'b0;
      aborted_ff <= 1'b0;
    end else begin
      if (centreEntry) begin
        blocked_ff <= 1'b1; // see RL12
      end else if (cwChanged) begin
        blocked_ff <= 1'b0; // see RL12
      end
      if (centreMove && cwChanged) begin
        aborted_ff <= 1'b1; // see RL11
      end else if (centreEntry) begin
        aborted_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstnSync) begin
    if (!rstnSync) begin
      ctrlWordOut_ff <= `PSCH_CW_RST;
      ctrlWordOutValid_ff <= 1'b0;
    end else begin
      ctrlWordOutValid_ff <= ctrlWordValid && (!blocked_ff || cwChanged); // see RL10
      ctrlWordOut_ff <= ctrlWordValid ? ctrlWord : ctrlWordOut_ff;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_RESET_STROBE: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL1
    (state_ff == psch_pkg::PSCH_IDLE && cmdNew_ff && cmdPend_ff == `PSCH_CMD_RESET)
      |=> driveReset_ff)
    else $error("Reset code did not reset the drive.");
  AST_FACT_SAVE: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL2
    (state_ff == psch_pkg::PSCH_WAIT_PARAM && storeDone && step_ff == 2'd1) |=> saveNvm_ff)
    else $error("Factory load was not followed by a save.");
  AST_USER_CENTRE: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL3
    (state_ff == psch_pkg::PSCH_WAIT_PARAM && storeDone && step_ff == 2'd2)
      |=> centreStart_ff)
    else $error("User load did not start the centring move.");
  AST_CLEAR_ID: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL4
    clearIdent_ff |-> loadFactory_ff)
    else $error("Identity cleared without factory load.");
  AST_USER_NOSAVE: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL5
    (loadUser_ff && step_ff == 2'd0) |-> !saveNvm_ff ##1 !saveNvm_ff)
    else $error("User load wrote memory.");
  AST_FACT_NOSAVE: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL6
    (loadFactory_ff && step_ff == 2'd0) |-> !clearIdent_ff && !saveNvm_ff)
    else $error("Factory load touched memory or identity.");
  AST_SAVE: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL7
    (startCmd && cmdPend_ff == `PSCH_CMD_SAVE) |=> saveNvm_ff && !loadFactory_ff)
    else $error("Save code did not save.");
  AST_VOLATILE: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL9
    $rose(rstnSync) |-> cmd_ff == `PSCH_CMD_RST)
    else $error("Command register not cleared at reset.");
  AST_IGNORE_CW: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL10
    (blocked_ff && ctrlWordValid && !cwChanged) |=> !ctrlWordOutValid_ff)
    else $error("Constant control word passed while blocked.");
  AST_ABORT: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL11
    (centreMove && cwChanged) |=> state_ff == psch_pkg::PSCH_IDLE && aborted_ff)
    else $error("Control word change did not abort centring.");
  AST_NO_RESUME: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL12
    (centreMove && centreDone && !cwChanged) |=> blocked_ff)
    else $error("Old run command not blocked after centring.");
  AST_UNKNOWN: assert property (@(posedge ref_clk) disable iff (!rstnSync) // see RL13
    (state_ff == psch_pkg::PSCH_IDLE && cmdNew_ff && !knownCmd)
      |=> state_ff == psch_pkg::PSCH_IDLE && !loadFactory_ff && !loadUser_ff && !saveNvm_ff)
    else $error("Unsupported code caused an action.");
endmodule // psch_cmd_handler

/* File: psch_store_model.sv */
// ----------------------------------------
// Parameter store and drive responder
// ----------------------------------------
module psch_store_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Requests from the handler
  input wire logic loadFactory,
  input wire logic loadUser,
  input wire logic saveNvm,
  input wire logic clearIdent,
  input wire logic centreStart,
  input wire logic centreAbort,
  // Answer timing
  input wire logic [3:0] dly,
  input wire logic stallCentre,
  // Answers
  output logic storeDone,
  output logic centreDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] storeCnt;
  logic [5:0] centreCnt;
  // A load with identity clearing is one store job, so it earns one answer.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      storeCnt <= 5'h00;
      storeDone <= 1'b0;
    end else begin
      storeDone <= (storeCnt == 5'h01);
      if (loadFactory | loadUser | saveNvm | clearIdent) begin
        storeCnt <= {1'b0, dly} + 5'h01;
      end else if (storeCnt != 5'h00) begin
        storeCnt <= storeCnt - 5'h01;
      end
    end
  end
  // A stalled move only ends by abort, which is what the abort case needs.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      centreCnt <= 6'h00;
      centreDone <= 1'b0;
    end else begin
      centreDone <= (centreCnt == 6'h01) && !stallCentre;
      if (centreStart) begin
        centreCnt <= 6'h20;
      end else if (centreAbort) begin
        centreCnt <= 6'h00;
      end else if (centreCnt != 6'h00 && !stallCentre) begin
        centreCnt <= centreCnt - 6'h01;
      end
    end
  end
endmodule // psch_store_model

/* File: tb_top.sv */
`include "psch_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err, ctrlWordValid;
  logic loadFactory, loadUser, saveNvm, clearIdent, driveReset, centreStart, centreAbort;
  logic storeDone, centreDone, fwdValid, stallCentre;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [15:0] ctrlWord, fwdWord, lastFwd;
  logic [3:0] dly;
  logic [15:0] codes [7];
  logic [15:0] bad [5];
  int err_total, total_checks, seed, n;
  int cnt [8];
  int snap [8];
  psch_cmd_handler uut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ctrlWord(ctrlWord), .ctrlWordValid(ctrlWordValid),
    .loadFactory_ff(loadFactory), .loadUser_ff(loadUser), .saveNvm_ff(saveNvm),
    .clearIdent_ff(clearIdent), .storeDone(storeDone), .driveReset_ff(driveReset),
    .centreStart_ff(centreStart), .centreAbort_ff(centreAbort), .centreDone(centreDone),
    .ctrlWordOut_ff(fwdWord), .ctrlWordOutValid_ff(fwdValid));
  psch_store_model model (.clk(ref_clk), .rstN(rstn), .loadFactory(loadFactory),
    .loadUser(loadUser), .saveNvm(saveNvm), .clearIdent(clearIdent),
    .centreStart(centreStart), .centreAbort(centreAbort), .dly(dly),
    .stallCentre(stallCentre), .storeDone(storeDone), .centreDone(centreDone));
  // ----------------------------------------
  // Clock, pulse counters, watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cnt[0] += loadFactory;
    cnt[1] += loadUser;
    cnt[2] += saveNvm;
    cnt[3] += clearIdent;
    cnt[4] += centreStart;
    cnt[5] += driveReset;
    cnt[6] += fwdValid;
    cnt[7] += centreAbort;
    if (fwdValid === 1'b1) lastFwd = fwdWord;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, `PSCH_ADDR_STATUS, 32'h0);
      k++;
    end while ((rd[`PSCH_ST_BUSY] | rd[`PSCH_ST_CENTRING]) !== 1'b0 && k < 100);
    if (k >= 100) check(rd, 32'h0);
  endtask
  task automatic cw(input logic [15:0] v);
    @(posedge ref_clk);
    ctrlWord <= v;
    ctrlWordValid <= 1'b1;
    @(posedge ref_clk);
    ctrlWordValid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // Bits: factory, user, save, clear identity, centre, drive reset.
  function automatic logic [5:0] expect_of(input logic [15:0] c);
    case (c)
      `PSCH_CMD_RESET: return 6'h20;
      `PSCH_CMD_FACT_SAVE_MID: return 6'h15;
      `PSCH_CMD_USER_MID: return 6'h12;
      `PSCH_CMD_FACT_CLR_ID: return 6'h0d;
      `PSCH_CMD_USER_LOAD: return 6'h02;
      `PSCH_CMD_FACT_LOAD: return 6'h01;
      `PSCH_CMD_SAVE: return 6'h04;
      default: return 6'h00;
    endcase
  endfunction
  // Upper data bits are random on purpose: the handler must ignore them.
  task automatic run_cmd(input logic [15:0] c);
    logic [5:0] e;
    logic [31:0] u;
    e = expect_of(c);
    u = $random(seed);
    snap = cnt;
    apb(1'b1, `PSCH_ADDR_CMD, {u[31:16], c});
    if (e != 6'h00) begin
      apb(1'b0, `PSCH_ADDR_CMD, 32'h0);
      check(rd, {{16{c[15]}}, c});
    end
    wait_idle();
    for (int i = 0; i < 6; i++) check(cnt[i] - snap[i], {31'h0, e[i]});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 43;
    err_total = 0;
    total_checks = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ctrlWord = `PSCH_CW_RST;
    ctrlWordValid = 1'b0;
    dly = 4'h2;
    stallCentre = 1'b0;
    lastFwd = 16'h0;
    codes = '{`PSCH_CMD_RESET, `PSCH_CMD_FACT_SAVE_MID, `PSCH_CMD_USER_MID,
      `PSCH_CMD_FACT_CLR_ID, `PSCH_CMD_USER_LOAD, `PSCH_CMD_FACT_LOAD, `PSCH_CMD_SAVE};
    bad = '{16'h0000, 16'h0002, 16'h7fff, 16'h8000, 16'hfff9};
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, `PSCH_ADDR_CMD, 32'h0);
    check(rd, {16'h0, `PSCH_CMD_RST});
    apb(1'b0, 12'h00c, 32'h0);
    check({rd[30:0], err}, 32'h1);
    foreach (codes[i]) run_cmd(codes[i]);
    foreach (bad[i]) run_cmd(bad[i]);
    // Random mix; legal codes except where an unsupported one is meant.
    repeat (12) begin
      r = $random(seed);
      dly <= r[3:0];
      if (r[8]) run_cmd(codes[r[7:4] % 7]);
      else run_cmd({1'b0, r[30:16]} | 16'h0002);
    end
    cw(16'h0014);
    check({16'h0, lastFwd}, 32'h14);
    run_cmd(`PSCH_CMD_USER_MID);
    snap = cnt;
    cw(16'h0014);
    check(cnt[6] - snap[6], 32'h0);
    cw(16'h0015);
    check(cnt[6] - snap[6], 32'h1);
    check({16'h0, lastFwd}, 32'h15);
    // Stalled move: a repeated word is ignored, a new one aborts.
    stallCentre <= 1'b1;
    snap = cnt;
    apb(1'b1, `PSCH_ADDR_CMD, {16'h0, `PSCH_CMD_USER_MID});
    n = 0;
    while (cnt[4] == snap[4] && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, n < 200}, 32'h1);
    cw(16'h0015);
    check(cnt[7] - snap[7], 32'h0);
    check(cnt[6] - snap[6], 32'h0);
    cw(16'h0016);
    check(cnt[7] - snap[7], 32'h1);
    apb(1'b0, `PSCH_ADDR_STATUS, 32'h0);
    check({31'h0, rd[`PSCH_ST_ABORTED]}, 32'h1);
    wait_idle();
    stallCentre <= 1'b0;
    apb(1'b0, `PSCH_ADDR_CTRLWORD, 32'h0);
    check({16'h0, rd[15:0]}, 32'h16);
    give_verdict();
  end
endmodule // tb_top
